// file: rtl/dopt_timer.sv
// dual output preset timer core: timing, thresholds, faults, output counter
//
// Contract
// - forecast: early output at set minus deviation
// - forecast: final output at main set value
// - deviation at least set: early output at start
// - absolute: first output at set value one
// - absolute: second output at set two, independent
// - processor fault: outputs off, key clears
// - memory fault: outputs off, key restores defaults
// - count alarm alternates display, outputs untouched
// - key hides alarm, count keeps counting
// - on-delay ignores start while timing runs
// - on-delay starts on start, power-up, reset release
// - on-delay clears at power-up, stops at set
// - outputs stay latched until reset
// - zero set value fires at start
// - cumulative advances with start, value retained
// - cumulative keeps advancing after time up
// - set changes take effect continuously
module dopt_timer
   import dopt_pkg::*;
#(
   parameter int TICK_CYC = BASE_TICK_CYC,
   parameter int BLINK_PERIOD_CYC = BLINK_CYC
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic start_in,
   input wire logic reset_input_in,
   input wire logic reset_key_in,
   input wire dopt_cfg_t cfg_in,
   input wire logic [PV_W-1:0] retained_pv_in,
   input wire logic cpu_fault_in,
   input wire logic mem_fault_in,
   input wire logic [CNT_W-1:0] count_alarm_limit_in,
   output logic early_or_first_output_out,
   output logic final_or_second_output_out,
   output logic indicator1_out,
   output logic indicator2_out,
   output logic [PV_W-1:0] pv_out,
   output logic cpu_error_out,
   output logic mem_error_out,
   output logic restore_defaults_out,
   output logic count_alarm_show_out,
   output logic [CNT_W-1:0] act_count_out
);
   logic [2:0] pins_s;
   logic start_d;
   logic reset_d;
   logic key_d;
   logic [1:0] settle;
   logic blink_tick;
   logic base_tick;
   logic blink_phase;
   logic alarm_ack;
   logic started;
   logic [15:0] prescale;
   dopt_state_t state;
   dopt_state_t next_state;

   dopt_sync #(.W(3)) u_sync (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .pin_in({reset_key_in, reset_input_in, start_in}),
      .sync_out(pins_s)
   );

   dopt_tick #(.CYC(TICK_CYC)) u_base (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .tick_out(base_tick)
   );

   dopt_tick #(.CYC(BLINK_PERIOD_CYC)) u_blink (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .tick_out(blink_tick)
   );

   // input events
   wire start_s = pins_s[0];
   wire reset_s = pins_s[1];
   wire key_s = pins_s[2];
   wire start_rise = start_s & ~start_d;
   wire reset_release = reset_d & ~reset_s;
   wire key_rise = key_s & ~key_d;
   wire reset_any = reset_s | key_s;
   wire fault_any = cpu_error_out | mem_error_out;
   wire settling = (settle != POWER_SETTLE);
   wire power_begin = (settle == POWER_SETTLE - 2'h1);
   wire cum = cfg_in.cumulative;

   // thresholds follow the set values every cycle
   wire [PV_W-1:0] dev = cfg_in.set2;
   wire dev_big = (dev >= cfg_in.set1);
   wire [PV_W-1:0] fc_th = dev_big ? PV_RESET : cfg_in.set1 - dev;
   wire [PV_W-1:0] th1 = cfg_in.absolute ? cfg_in.set1 : fc_th;
   wire [PV_W-1:0] th2 = cfg_in.absolute ? cfg_in.set2 : cfg_in.set1;
   wire [PV_W-1:0] th_end = (cfg_in.absolute && cfg_in.set1 > cfg_in.set2) ? cfg_in.set1 : th2;

   // on-delay begins on a start edge, or with start held at power-up or reset release
   wire begin_req = start_rise | (start_s & (power_begin | reset_release));
   wire begin_ok = ~cum & (state == DOPT_IDLE) & begin_req & ~reset_any & ~fault_any;
   wire cum_run = cum & start_s & ~reset_any & ~fault_any & ~settling;
   wire active = cum ? (started | cum_run) : (state != DOPT_IDLE) | begin_ok;

   // unit step of the selected range
   wire [15:0] scale = (cfg_in.range == RANGE_HUNDREDTH_S) ? SCALE_HUNDREDTH_S :
                       (cfg_in.range == RANGE_SEC) ? SCALE_SEC :
                       (cfg_in.range == RANGE_TENTH_MIN) ? SCALE_TENTH_MIN : SCALE_TENTH_H;
   wire advancing = cum ? cum_run : (state == DOPT_RUN) & ~reset_any & ~fault_any;
   wire unit_tick = advancing & base_tick & (prescale >= scale - 16'h0001);
   wire pv_max = &pv_out;
   wire [PV_W-1:0] next_pv = (unit_tick && !pv_max) ? pv_out + PV_W'(1) : pv_out;

   // outputs compare continuously, latch, and drop on reset or fault
   wire hit1 = active & (pv_out >= th1);
   wire hit2 = active & (pv_out >= th2);
   wire next_early_or_first_output = ~reset_any & ~fault_any & (early_or_first_output_out | hit1);
   wire next_final_or_second_output = ~reset_any & ~fault_any & (final_or_second_output_out | hit2);
   wire out_rise = (next_early_or_first_output & ~early_or_first_output_out)
                 | (next_final_or_second_output & ~final_or_second_output_out);
   wire count_alarm = (act_count_out > count_alarm_limit_in);

   always_comb begin
      next_state = state;
      unique case (state)
         DOPT_IDLE: begin
            if (begin_ok) begin
               next_state = DOPT_RUN;
            end
         end
         DOPT_RUN: begin
            if (reset_any || cum) begin
               next_state = DOPT_IDLE;
            end else if (pv_out >= th_end) begin
               next_state = DOPT_UP;
            end
         end
         DOPT_UP: begin
            if (reset_any || cum) begin
               next_state = DOPT_IDLE;
            end
         end
         default: next_state = DOPT_IDLE;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         start_d <= 1'b0;
         reset_d <= 1'b0;
         key_d <= 1'b0;
         settle <= 2'h0;
         state <= DOPT_IDLE;
         started <= 1'b0;
         prescale <= 16'h0000;
      end else begin
         start_d <= start_s;
         reset_d <= reset_s;
         key_d <= key_s;
         settle <= settling ? settle + 2'h1 : settle;
         state <= next_state;
         // cumulative outputs stay armed once timing has run since the last reset
         started <= cum & ~reset_any & (started | cum_run);
         if (!advancing || unit_tick) begin
            prescale <= 16'h0000;
         end else if (base_tick) begin
            prescale <= prescale + 16'h0001;
         end
      end
   end

   // present value: cleared at power-up in on-delay, reloaded from backup when cumulative
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         pv_out <= PV_RESET;
      end else if (settle == 2'h0) begin
         pv_out <= cum ? retained_pv_in : PV_RESET;
      end else if (reset_any || begin_ok) begin
         pv_out <= PV_RESET;
      end else begin
         pv_out <= next_pv;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         early_or_first_output_out <= 1'b0;
         final_or_second_output_out <= 1'b0;
         indicator1_out <= 1'b0;
         indicator2_out <= 1'b0;
      end else begin
         early_or_first_output_out <= next_early_or_first_output;
         final_or_second_output_out <= next_final_or_second_output;
         indicator1_out <= next_early_or_first_output;
         indicator2_out <= next_final_or_second_output;
      end
   end

   // faults: a new fault in the key cycle wins over the clear
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         cpu_error_out <= 1'b0;
         mem_error_out <= 1'b0;
         restore_defaults_out <= 1'b0;
      end else begin
         cpu_error_out <= cpu_fault_in | (cpu_error_out & ~key_rise);
         mem_error_out <= mem_fault_in | (mem_error_out & ~key_rise);
         restore_defaults_out <= mem_error_out & key_rise & ~mem_fault_in;
      end
   end

   // activation counter never clears; the key only hides the alarm
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         act_count_out <= COUNT_RESET;
         alarm_ack <= 1'b0;
         blink_phase <= 1'b0;
         count_alarm_show_out <= 1'b0;
      end else begin
         if (out_rise && !(&act_count_out)) begin
            act_count_out <= act_count_out + CNT_W'(1);
         end
         alarm_ack <= count_alarm & (alarm_ack | key_rise);
         blink_phase <= blink_tick ? ~blink_phase : blink_phase;
         count_alarm_show_out <= count_alarm & ~alarm_ack & ~key_rise & blink_phase;
      end
   end

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   a_early_or_first_output_threshold: assert property (hit1 && !reset_any && !fault_any |=> early_or_first_output_out)
      else $error("early or first output missed its threshold");
   a_final_or_second_output_threshold: assert property (hit2 && !reset_any && !fault_any |=> final_or_second_output_out)
      else $error("final or second output missed its threshold");
   a_early_big_dev: assert property (!cfg_in.absolute && dev_big && begin_ok && !reset_any |=> ##1 early_or_first_output_out)
      else $error("early output late with deviation at least set value");
   a_fault_off: assert property (fault_any |=> !early_or_first_output_out && !final_or_second_output_out)
      else $error("output on during a fault");
   a_mem_restore: assert property (mem_error_out && key_rise && !mem_fault_in |=> restore_defaults_out ##1 !restore_defaults_out)
      else $error("defaults not restored once after memory fault");
   a_alarm_hidden: assert property (alarm_ack |=> !count_alarm_show_out || !alarm_ack)
      else $error("acknowledged alarm still shown");
   a_count_kept: assert property (key_rise |=> act_count_out >= $past(act_count_out))
      else $error("activation count dropped on key");
   a_start_ignored: assert property (state == DOPT_RUN && start_rise && !reset_any && !fault_any |=> pv_out >= $past(pv_out))
      else $error("start during timing restarted the interval");
   a_ondelay_stop: assert property (!cum && state == DOPT_UP && !reset_any && !settling |=> pv_out == $past(pv_out))
      else $error("on-delay value moved after time up");
   a_latched_out: assert property (early_or_first_output_out && !reset_any && !fault_any |=> early_or_first_output_out)
      else $error("output dropped without reset");
   a_cum_hold: assert property (cum && !start_s && !reset_any && settle == POWER_SETTLE |=> pv_out == $past(pv_out))
      else $error("cumulative value moved with start off");

   // step checks skip the settle cycles, where the backup value is loaded
   a_pv_step: assert property (unit_tick && !pv_max && !reset_any && !begin_ok && !settling
      |=> pv_out == $past(pv_out) + PV_W'(1))
      else $error("present value did not step on a unit tick");
   a_pv_no_skip: assert property (!unit_tick && !reset_any && !begin_ok && !settling
      |=> pv_out == $past(pv_out))
      else $error("present value moved without a unit tick");
   a_cum_past_set: assert property (cum && unit_tick && !pv_max && pv_out >= th_end
      |=> pv_out != $past(pv_out))
      else $error("cumulative value stopped after time up");
   a_cum_armed: assert property (cum && cum_run |=> started)
      else $error("cumulative run did not arm the outputs");
   a_ondelay_up: assert property (!cum && state == DOPT_RUN && pv_out >= th_end && !reset_any
      |=> state == DOPT_UP)
      else $error("on-delay did not stop at the set time");
   a_state_legal: assert property (state inside {DOPT_IDLE, DOPT_RUN, DOPT_UP})
      else $error("timer state left its legal codes");

   a_begin_edge: assert property (!cum && state == DOPT_IDLE && start_rise && !reset_any
      && !fault_any |=> state == DOPT_RUN)
      else $error("start edge did not begin timing");
   a_begin_zero: assert property (begin_ok |=> pv_out == PV_RESET)
      else $error("present value not cleared when timing begins");
   a_zero_set: assert property (begin_ok && cfg_in.absolute && cfg_in.set1 == PV_RESET
      |=> early_or_first_output_out)
      else $error("zero set value did not fire at start");
   a_second_abs: assert property (cfg_in.absolute && active && pv_out >= cfg_in.set2
      && !reset_any && !fault_any |=> final_or_second_output_out)
      else $error("second output missed set value two");
   a_out_drop: assert property (reset_any |=> !early_or_first_output_out
      && !final_or_second_output_out)
      else $error("output stayed on through a reset");
   a_ind_mirror: assert property (indicator1_out == early_or_first_output_out
      && indicator2_out == final_or_second_output_out)
      else $error("indicators differ from the outputs");

   a_cpu_err_set: assert property (cpu_fault_in |=> cpu_error_out)
      else $error("processor fault not shown");
   a_cpu_err_clear: assert property (cpu_error_out && key_rise && !cpu_fault_in
      |=> !cpu_error_out)
      else $error("processor fault not cleared by the key");
   a_mem_err_set: assert property (mem_fault_in |=> mem_error_out)
      else $error("memory fault not shown");
   a_restore_once: assert property (restore_defaults_out |=> !restore_defaults_out)
      else $error("restore pulse longer than one cycle");

   a_alarm_quiet: assert property (!count_alarm |=> !count_alarm_show_out)
      else $error("alarm shown below its threshold");
   a_count_step: assert property (out_rise && !(&act_count_out)
      |=> act_count_out == $past(act_count_out) + CNT_W'(1))
      else $error("activation count missed an output rise");
   a_count_no_clear: assert property (1'b1 |=> act_count_out >= $past(act_count_out))
      else $error("activation count went down");
endmodule : dopt_timer

// file: rtl/dopt_pkg.sv
// shared constants and types for the dual output preset timer
package dopt_pkg;
   localparam int PV_W = 20;
   localparam int CNT_W = 24;
   localparam int CLK_MHZ = 50;
   // base tick of 10 ms and the alarm blink half period, in their own units
   localparam int BASE_TICK_US = 10000;
   localparam int BLINK_MS = 500;
   localparam int BASE_TICK_CYC = BASE_TICK_US * CLK_MHZ;
   localparam int BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
   // base ticks per present value unit, one per time range
   localparam logic [15:0] SCALE_TENTH_H = 16'h8ca0;
   localparam logic [15:0] SCALE_HUNDREDTH_S = 16'h0001;
   localparam logic [15:0] SCALE_SEC = 16'h0064;
   localparam logic [15:0] SCALE_TENTH_MIN = 16'h0258;
   localparam logic [1:0] RANGE_TENTH_H = 2'h0;
   localparam logic [1:0] RANGE_HUNDREDTH_S = 2'h1;
   localparam logic [1:0] RANGE_SEC = 2'h2;
   localparam logic [1:0] RANGE_TENTH_MIN = 2'h3;
   // cycles after power-up before a held start may begin timing
   localparam logic [1:0] POWER_SETTLE = 2'h3;
   localparam logic [PV_W-1:0] PV_RESET = 20'h00000;
   localparam logic [CNT_W-1:0] COUNT_RESET = 24'h000000;

   typedef enum logic [1:0] {
      DOPT_IDLE = 2'b00,
      DOPT_RUN = 2'b01,
      DOPT_UP = 2'b10
   } dopt_state_t;

   typedef struct packed {
      logic cumulative;
      logic absolute;
      logic [1:0] range;
      logic [PV_W-1:0] set1;
      logic [PV_W-1:0] set2;
   } dopt_cfg_t;
endpackage : dopt_pkg

// file: rtl/dopt_sync.sv
// two flip-flop synchroniser for a group of pin inputs
module dopt_sync #(
   parameter int W = 3
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] sync_out
);
   // each bit owns its flops, so no vector is written from several processes
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic meta;
      logic held;
      always_ff @(posedge clock_in) begin
         if (!rst_n_in) begin
            meta <= 1'b0;
            held <= 1'b0;
         end else begin
            meta <= pin_in[i];
            held <= meta;
         end
      end
      assign sync_out[i] = held;
   end
endmodule : dopt_sync

// file: rtl/dopt_tick.sv
// free running divider giving a one-cycle enable pulse every CYC cycles
module dopt_tick #(
   parameter int CYC = 500000
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   output logic tick_out
);
   localparam int CW = $clog2(CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(CYC - 1);
   logic [CW-1:0] count;
   wire wrap = (count == LAST);

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         count <= '0;
         tick_out <= 1'b0;
      end else begin
         count <= wrap ? '0 : count + CW'(1);
         tick_out <= wrap;
      end
   end
endmodule : dopt_tick

// file: test/dopt_partner.sv
// switch and sensor model driving the start, reset and key pins of the timer
module dopt_partner (
   input wire logic clock_in,
   input wire logic start_req_in,
   input wire logic reset_req_in,
   input wire logic key_req_in,
   output logic start_out,
   output logic reset_out,
   output logic key_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      start_out = 1'b0;
      reset_out = 1'b0;
      key_out = 1'b0;
   end
   // contacts move a little after the edge, like a real switch unrelated to the clock
   always @(posedge clock_in) begin
      start_out <= #3 start_req_in;
      reset_out <= #3 reset_req_in;
      key_out <= #3 key_req_in;
   end
endmodule : dopt_partner

// file: test/dopt_timer_tb.sv
// self-checking testbench for the dual output preset timer core
module dopt_timer_tb
   import dopt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic start_req = 1'b0, rst_req = 1'b0, key_req = 1'b0;
   logic start_pin, rst_pin, key_pin;
   dopt_cfg_t cfg_in = '0;
   logic [PV_W-1:0] retained_pv_in = '0;
   logic cpu_fault_in = 1'b0, mem_fault_in = 1'b0;
   logic [CNT_W-1:0] count_alarm_limit_in = 24'hffffff;
   logic early_or_first_output, final_or_second_output, ind1, ind2, cpu_err, mem_err, restore, show, p1, p2;
   logic [PV_W-1:0] pv_out, p0, s1, s2;
   logic [CNT_W-1:0] act_count_out, c0;
   logic [PV_W:0] q[$];
   int fail_count = 0, n_tests = 0, cycles = 0, seed = 32'h8f2a, ones;
   always #10 clock_in = ~clock_in;
   dopt_partner u_partner (.clock_in(clock_in), .start_req_in(start_req), .reset_req_in(rst_req),
      .key_req_in(key_req), .start_out(start_pin), .reset_out(rst_pin), .key_out(key_pin));
   dopt_timer #(.TICK_CYC(10), .BLINK_PERIOD_CYC(4)) dut (.clock_in(clock_in),
      .rst_n_in(rst_n_in), .start_in(start_pin), .reset_input_in(rst_pin),
      .reset_key_in(key_pin), .cfg_in(cfg_in), .retained_pv_in(retained_pv_in),
      .cpu_fault_in(cpu_fault_in), .mem_fault_in(mem_fault_in),
      .count_alarm_limit_in(count_alarm_limit_in), .early_or_first_output_out(early_or_first_output),
      .final_or_second_output_out(final_or_second_output), .indicator1_out(ind1), .indicator2_out(ind2),
      .pv_out(pv_out), .cpu_error_out(cpu_err), .mem_error_out(mem_err),
      .restore_defaults_out(restore), .count_alarm_show_out(show), .act_count_out(act_count_out));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_in);
   endtask : cyc
   task automatic look();
      @(negedge clock_in);
   endtask : look
   task automatic power(input logic st);
      rst_n_in <= 1'b0;
      start_req <= st;
      cyc(8);
      rst_n_in <= 1'b1;
   endtask : power
   task automatic key();
      key_req <= 1'b1;
      cyc(5);
      key_req <= 1'b0;
      cyc(5);
   endtask : key
   // restart from idle: start low, key clears, new settings, then a start edge
   task automatic go(input logic cum, input logic abs, input logic [PV_W-1:0] a,
                     input logic [PV_W-1:0] b);
      start_req <= 1'b0;
      key();
      cfg_in <= {cum, abs, RANGE_HUNDREDTH_S, a, b};
      start_req <= 1'b1;
   endtask : go
   task automatic drain();
      int w;
      w = 0;
      while (q.size() > 0 && w < 2000) begin
         cyc(1);
         w++;
      end
      chk(32'(q.size()), 32'h0);
   endtask : drain
   // watcher: every output rise takes the oldest note and compares the present value
   always @(negedge clock_in) begin
      if (rst_n_in) begin
         if (early_or_first_output && !p1) begin
            chk({11'h0, 1'b0, pv_out}, {11'h0, (q.size() > 0) ? q.pop_front() : 21'h1fffff});
         end
         if (final_or_second_output && !p2) begin
            chk({11'h0, 1'b1, pv_out}, {11'h0, (q.size() > 0) ? q.pop_front() : 21'h1fffff});
         end
         chk({ind1, ind2}, {early_or_first_output, final_or_second_output});
      end
      p1 <= early_or_first_output;
      p2 <= final_or_second_output;
   end
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         conclude();
      end
   end
   initial begin
      cfg_in <= {1'b0, 1'b0, RANGE_HUNDREDTH_S, 20'h3, 20'h1};
      q = '{{1'b0, 20'h2}, {1'b1, 20'h3}};
      power(1'b1);
      cyc(1);
      look();
      chk(pv_out, 20'h0);
      drain();
      cyc(50);
      look();
      chk({pv_out, early_or_first_output, final_or_second_output}, {20'h3, 2'b11});
      q = '{{1'b0, 20'h4}, {1'b1, 20'h6}};
      go(1'b0, 1'b0, 20'h6, 20'h2);
      cyc(25);
      look();
      p0 = pv_out;
      start_req <= 1'b0;
      cyc(6);
      start_req <= 1'b1;
      cyc(6);
      look();
      chk(pv_out >= p0, 1);
      drain();
      key();
      look();
      chk({pv_out, early_or_first_output, final_or_second_output}, 22'h0);
      q = '{{1'b0, 20'h0}, {1'b1, 20'h6}};
      go(1'b0, 1'b0, 20'h6, 20'h8);
      drain();
      for (int i = 0; i < 3; i++) begin
         s1 = (i == 0) ? 20'h0 : 20'($unsigned($random(seed)) & 7);
         s2 = s1 + 20'h1 + 20'($unsigned($random(seed)) & 3);
         q = '{{1'b0, s1}, {1'b1, s2}};
         go(1'b0, 1'b1, s1, s2);
         drain();
      end
      go(1'b0, 1'b1, 20'h14, 20'h1e);
      for (int w = 0; w < 200 && pv_out !== 20'h8; w++) look();
      q = '{{1'b0, 20'h8}, {1'b1, 20'h8}};
      cfg_in <= {1'b0, 1'b1, RANGE_HUNDREDTH_S, 20'h4, 20'h8};
      drain();
      cpu_fault_in <= 1'b1;
      cyc(1);
      cpu_fault_in <= 1'b0;
      cyc(2);
      look();
      chk({early_or_first_output, final_or_second_output, cpu_err}, 3'b001);
      key();
      look();
      chk(cpu_err, 0);
      q = '{{1'b0, 20'h0}, {1'b1, 20'h0}};
      go(1'b0, 1'b0, 20'h0, 20'h0);
      drain();
      mem_fault_in <= 1'b1;
      cyc(1);
      mem_fault_in <= 1'b0;
      cyc(2);
      look();
      chk({early_or_first_output, final_or_second_output, mem_err}, 3'b001);
      key_req <= 1'b1;
      ones = 0;
      repeat (12) begin
         look();
         ones += int'(restore === 1'b1);
      end
      key_req <= 1'b0;
      chk({ones, mem_err}, {31'h1, 1'b0});
      look();
      c0 = act_count_out;
      count_alarm_limit_in <= c0;
      q = '{{1'b0, 20'h1}, {1'b1, 20'h2}};
      go(1'b0, 1'b0, 20'h2, 20'h1);
      drain();
      cyc(2);
      ones = 0;
      repeat (8) begin
         look();
         ones += int'(show === 1'b1);
      end
      chk({act_count_out, early_or_first_output, final_or_second_output, ones > 0, ones < 8}, {c0 + 24'h2, 4'hf});
      key();
      ones = 0;
      repeat (8) begin
         look();
         ones += int'(show === 1'b1);
      end
      chk({act_count_out, ones}, {c0 + 24'h2, 32'h0});
      cfg_in <= {1'b1, 1'b1, RANGE_HUNDREDTH_S, 20'h7, 20'h9};
      retained_pv_in <= 20'h5;
      q = '{{1'b0, 20'h7}, {1'b1, 20'h9}};
      power(1'b1);
      cyc(1);
      look();
      chk(pv_out, 20'h5);
      drain();
      cyc(40);
      look();
      chk(pv_out > 20'h9, 1);
      start_req <= 1'b0;
      cyc(4);
      look();
      p0 = pv_out;
      cyc(30);
      look();
      chk(pv_out, p0);
      conclude();
   end
endmodule : dopt_timer_tb
